// >>> ccrs_pkg.sv
// constants and types for the converter configuration register slice
// What this block does
// - 24-bit read-only sync edge position status
// - 16-bit full-scale register, reset 0xA000, all channels
// - code 0x2000/0xA000/0xFFFF gives 500/800/1000 mVPP
// - power profile resets 0x4B; 0x46 low power
// - timestamp bit 0 enables input receiver
// - timestamp bit 1 selects PECL termination mode
// - reference output drive follows synthesizer enable one cycle late
// - reference output enable resets to one
// - feedback divider resets 0x00; post 3:2, first 1:0
// - post 1/2/4, first 5/4/3, code 3 reserved
package ccrs_pkg;
    localparam logic [14:0] ADDR_SYNC_POS_0 = 15'h002C;
    localparam logic [14:0] ADDR_SYNC_POS_1 = 15'h002D;
    localparam logic [14:0] ADDR_SYNC_POS_2 = 15'h002E;
    localparam logic [14:0] ADDR_FS_LO      = 15'h0030;
    localparam logic [14:0] ADDR_FS_HI      = 15'h0031;
    localparam logic [14:0] ADDR_PWR        = 15'h0037;
    localparam logic [14:0] ADDR_TSTMP      = 15'h003B;
    localparam logic [14:0] ADDR_REFO       = 15'h003C;
    localparam logic [14:0] ADDR_FBDIV      = 15'h003D;

    localparam logic [15:0] FS_RESET    = 16'hA000;
    localparam logic [7:0]  PWR_RESET   = 8'h4B;
    localparam logic [7:0]  PWR_LOW     = 8'h46;
    localparam logic [7:0]  TSTMP_RESET = 8'h00;
    localparam logic [7:0]  REFO_RESET  = 8'h01;
    localparam logic [7:0]  FBDIV_RESET = 8'h00;

    localparam int TS_EN_BIT     = 0;
    localparam int TS_PECL_BIT   = 1;
    localparam int REFO_EN_BIT   = 0;
    localparam int POST_DIV_LSB  = 2;
    localparam int FIRST_DIV_LSB = 0;

    // serial frame: read flag, 15 address bits, then data bytes
    localparam logic [4:0] BIT_ADDR_LAST = 5'h0F;
    localparam logic [4:0] BIT_DATA_0    = 5'h10;
    localparam logic [4:0] BIT_DATA_LAST = 5'h17;

    localparam logic [2:0] DIV_NONE = 3'h0;
    localparam logic [2:0] DIV_1    = 3'h1;
    localparam logic [2:0] DIV_2    = 3'h2;
    localparam logic [2:0] DIV_3    = 3'h3;
    localparam logic [2:0] DIV_4    = 3'h4;
    localparam logic [2:0] DIV_5    = 3'h5;

    typedef struct packed {
        logic [15:0] fs;
        logic [7:0]  pwr;
        logic [7:0]  tstmp;
        logic [7:0]  refo;
        logic [7:0]  fbdiv;
    } ccrs_regs_t;

    typedef struct packed {
        logic [15:0] full_scale_adjust;
        logic [7:0]  power_profile_code;
        logic        low_power_sel;
        logic        timestamp_input_enable;
        logic        timestamp_pecl_mode;
        logic        synth_ref_output_drive;
        logic [2:0]  post_div_ratio;
        logic [2:0]  first_div_ratio;
    } ccrs_ctrl_t;
endpackage

// >>> ccrs_top.sv
// serial-port register slice of the converter configuration map
`timescale 1ns/1ps
module ccrs_top (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              spi_sclk,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_sdi,
    input  wire logic [23:0]       sync_edge_position,
    input  wire logic              synth_enable,
    output logic                   spi_sdo,
    output logic                   spi_sdo_oe,
    output ccrs_pkg::ccrs_ctrl_t   ctrl
);
    // third sclk stage feeds only the edge detector
    logic [2:0]           sclk_q;
    logic [2:0]           next_sclk_q;
    logic [1:0]           cs_n_q;
    logic [1:0]           next_cs_n_q;
    logic [1:0]           sdi_q;
    logic [1:0]           next_sdi_q;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 cs_act;
    logic                 sdi_s;

    logic [4:0]           bit_cnt;
    logic [4:0]           next_bit_cnt;
    logic                 is_read;
    logic                 next_is_read;
    logic [14:0]          addr;
    logic [14:0]          next_addr;
    logic [7:0]           shift_in;
    logic [7:0]           next_shift_in;
    logic [7:0]           shift_out;
    logic [7:0]           next_shift_out;
    logic                 next_sdo;
    logic                 next_sdo_oe;
    logic                 wr_en;
    logic [14:0]          wr_addr;
    logic [7:0]           wr_data;

    ccrs_pkg::ccrs_regs_t regs;
    ccrs_pkg::ccrs_regs_t next_regs;
    ccrs_pkg::ccrs_ctrl_t next_ctrl;

    // byte readback; status bytes come live from the capture logic
    function automatic logic [7:0] read_byte(input logic [14:0] a,
                                             input ccrs_pkg::ccrs_regs_t r,
                                             input logic [23:0] pos);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ccrs_pkg::ADDR_SYNC_POS_0: d = pos[7:0];
            ccrs_pkg::ADDR_SYNC_POS_1: d = pos[15:8];
            ccrs_pkg::ADDR_SYNC_POS_2: d = pos[23:16];
            ccrs_pkg::ADDR_FS_LO:      d = r.fs[7:0];
            ccrs_pkg::ADDR_FS_HI:      d = r.fs[15:8];
            ccrs_pkg::ADDR_PWR:        d = r.pwr;
            ccrs_pkg::ADDR_TSTMP:      d = r.tstmp;
            ccrs_pkg::ADDR_REFO:       d = r.refo;
            ccrs_pkg::ADDR_FBDIV:      d = r.fbdiv;
            default:                   d = 8'h00;
        endcase
        return d;
    endfunction

    // pin synchronisers
    always_comb begin
        next_sclk_q = {sclk_q[1:0], spi_sclk};
        next_cs_n_q = {cs_n_q[0], spi_cs_n};
        next_sdi_q  = {sdi_q[0], spi_sdi};
    end

    // reset levels match idle pins, so no false edge after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h0;
            cs_n_q <= 2'h3;
            sdi_q  <= 2'h0;
        end else begin
            sclk_q <= next_sclk_q;
            cs_n_q <= next_cs_n_q;
            sdi_q  <= next_sdi_q;
        end
    end

    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign cs_act    = ~cs_n_q[1];
    assign sdi_s     = sdi_q[1];

    // serial frame engine, mode 0, msb first
    always_comb begin
        next_bit_cnt   = bit_cnt;
        next_is_read   = is_read;
        next_addr      = addr;
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_sdo       = spi_sdo;
        next_sdo_oe    = spi_sdo_oe;
        wr_en          = 1'b0;
        wr_addr        = addr;
        wr_data        = {shift_in[6:0], sdi_s};
        if (!cs_act) begin
            next_bit_cnt = 5'h00;
            next_is_read = 1'b0;
            next_sdo     = 1'b0;
            next_sdo_oe  = 1'b0;
        end else if (sclk_rise) begin
            if (bit_cnt == 5'h00) begin
                next_is_read = sdi_s;
            end else if (bit_cnt <= ccrs_pkg::BIT_ADDR_LAST) begin
                next_addr = {addr[13:0], sdi_s};
            end else begin
                next_shift_in = {shift_in[6:0], sdi_s};
            end
            // fetch the first byte with the last address bit
            if (bit_cnt == ccrs_pkg::BIT_ADDR_LAST) begin
                next_shift_out = read_byte({addr[13:0], sdi_s}, regs, sync_edge_position);
            end
            // eighth data bit commits, then streams to address + 1
            if (bit_cnt == ccrs_pkg::BIT_DATA_LAST) begin
                wr_en          = ~is_read;
                next_addr      = addr + 15'h0001;
                next_shift_out = read_byte(addr + 15'h0001, regs, sync_edge_position);
                next_bit_cnt   = ccrs_pkg::BIT_DATA_0;
            end else begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end else if (sclk_fall && is_read && bit_cnt >= ccrs_pkg::BIT_DATA_0) begin
            next_sdo       = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
            next_sdo_oe    = 1'b1;
        end
    end

    // sdo and its enable leave straight from flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt    <= 5'h00;
            is_read    <= 1'b0;
            addr       <= 15'h0000;
            shift_in   <= 8'h00;
            shift_out  <= 8'h00;
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            bit_cnt    <= next_bit_cnt;
            is_read    <= next_is_read;
            addr       <= next_addr;
            shift_in   <= next_shift_in;
            shift_out  <= next_shift_out;
            spi_sdo    <= next_sdo;
            spi_sdo_oe <= next_sdo_oe;
        end
    end

    // register writes; status bytes have no storage and drop writes
    // reserved bits are stored and read back as written
    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            case (wr_addr)
                ccrs_pkg::ADDR_FS_LO: next_regs.fs[7:0]  = wr_data;
                ccrs_pkg::ADDR_FS_HI: next_regs.fs[15:8] = wr_data;
                ccrs_pkg::ADDR_PWR:   next_regs.pwr      = wr_data;
                ccrs_pkg::ADDR_TSTMP: next_regs.tstmp    = wr_data;
                ccrs_pkg::ADDR_REFO:  next_regs.refo     = wr_data;
                ccrs_pkg::ADDR_FBDIV: next_regs.fbdiv    = wr_data;
                default:              next_regs          = regs;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs.fs    <= ccrs_pkg::FS_RESET;
            regs.pwr   <= ccrs_pkg::PWR_RESET;
            regs.tstmp <= ccrs_pkg::TSTMP_RESET;
            regs.refo  <= ccrs_pkg::REFO_RESET;
            regs.fbdiv <= ccrs_pkg::FBDIV_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    // decoded controls toward the analog and clocking blocks
    always_comb begin
        next_ctrl.full_scale_adjust      = regs.fs;
        next_ctrl.power_profile_code     = regs.pwr;
        next_ctrl.low_power_sel          = (regs.pwr == ccrs_pkg::PWR_LOW);
        next_ctrl.timestamp_input_enable = regs.tstmp[ccrs_pkg::TS_EN_BIT];
        next_ctrl.timestamp_pecl_mode    = regs.tstmp[ccrs_pkg::TS_PECL_BIT];
        // drive follows synth_enable one cycle late
        next_ctrl.synth_ref_output_drive = regs.refo[ccrs_pkg::REFO_EN_BIT]
                                           & synth_enable;
        // reserved divider codes decode to ratio zero
        case (regs.fbdiv[ccrs_pkg::POST_DIV_LSB +: 2])
            2'h0:    next_ctrl.post_div_ratio = ccrs_pkg::DIV_1;
            2'h1:    next_ctrl.post_div_ratio = ccrs_pkg::DIV_2;
            2'h2:    next_ctrl.post_div_ratio = ccrs_pkg::DIV_4;
            default: next_ctrl.post_div_ratio = ccrs_pkg::DIV_NONE;
        endcase
        case (regs.fbdiv[ccrs_pkg::FIRST_DIV_LSB +: 2])
            2'h0:    next_ctrl.first_div_ratio = ccrs_pkg::DIV_5;
            2'h1:    next_ctrl.first_div_ratio = ccrs_pkg::DIV_4;
            2'h2:    next_ctrl.first_div_ratio = ccrs_pkg::DIV_3;
            default: next_ctrl.first_div_ratio = ccrs_pkg::DIV_NONE;
        endcase
    end

    // controls change only on this edge, or clear to zero at once on reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end
endmodule

// >>> ccrs_host.sv
// serial port host model that frames register accesses
`timescale 1ns/1ps
module ccrs_host (
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // five core clocks per sclk phase, above the four-clock minimum
    task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rw, addr, wd};
        rdat = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi <= frame[i];
            repeat (5) @(posedge clk);
            if (i < 8) rdat[i] = sdo;
            sclk <= 1'b1;
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        sdi  <= ~frame[0];
        repeat (10) @(posedge clk);
    endtask
endmodule

// >>> ccrs_top_chk.sv
// port assertions for the register slice
`timescale 1ns/1ps
module ccrs_top_chk (
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic            spi_sclk,
    input wire logic            spi_cs_n,
    input wire logic            spi_sdi,
    input wire logic [23:0]     sync_edge_position,
    input wire logic            synth_enable,
    input wire logic            spi_sdo,
    input wire logic            spi_sdo_oe,
    input ccrs_pkg::ccrs_ctrl_t ctrl
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_idle;
        spi_cs_n [*8];
    endsequence
    property p_reset;
        $rose(rst_n) |=> ctrl.full_scale_adjust == 16'hA000 && ctrl.power_profile_code == 8'h4B
            && ctrl.post_div_ratio == 3'h1 && ctrl.first_div_ratio == 3'h5;
    endproperty
    property p_low;
        ctrl.low_power_sel == (ctrl.power_profile_code == 8'h46);
    endproperty
    property p_drive;
        ctrl.synth_ref_output_drive |-> $past(synth_enable);
    endproperty
    property p_post;
        ctrl.post_div_ratio inside {3'h0, 3'h1, 3'h2, 3'h4};
    endproperty
    property p_first;
        ctrl.first_div_ratio inside {3'h0, 3'h3, 3'h4, 3'h5};
    endproperty
    property p_oe_off;
        s_idle |-> !spi_sdo_oe;
    endproperty
    property p_oe_on;
        $rose(spi_sdo_oe) |-> !spi_cs_n && !spi_sclk;
    endproperty
    property p_quiet;
        s_idle |-> $stable({ctrl.full_scale_adjust, ctrl.power_profile_code, ctrl.low_power_sel,
            ctrl.timestamp_input_enable, ctrl.timestamp_pecl_mode, ctrl.post_div_ratio,
            ctrl.first_div_ratio});
    endproperty
    a_reset: assert property (p_reset) else $error("reset decode wrong");
    a_low: assert property (p_low) else $error("low power decode wrong");
    a_drive: assert property (p_drive) else $error("ref drive without enable");
    a_post: assert property (p_post) else $error("post ratio illegal");
    a_first: assert property (p_first) else $error("first ratio illegal");
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while idle");
    a_oe_on: assert property (p_oe_on) else $error("sdo enabled off frame");
    a_quiet: assert property (p_quiet) else $error("ctrl moved while idle");
endmodule
bind ccrs_top ccrs_top_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .sync_edge_position(sync_edge_position),
    .synth_enable(synth_enable), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ctrl(ctrl));

// >>> ccrs_top_bench.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
module ccrs_top_bench;
    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [23:0]          sync_edge_position = 24'hC3A55A;
    logic                 synth_enable = 1'b1;
    logic                 spi_sclk;
    logic                 spi_cs_n;
    logic                 spi_sdi;
    logic                 spi_sdo;
    logic                 spi_sdo_oe;
    ccrs_pkg::ccrs_ctrl_t ctrl;
    int                   errors = 0;
    int                   tests_run = 0;
    logic [7:0]           rdat;
    logic [2:0]           post_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [2:0]           first_exp [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    always #12.5 core_clk = ~core_clk;
    ccrs_host host (.clk(core_clk), .sdo(spi_sdo), .sclk(spi_sclk), .cs_n(spi_cs_n),
        .sdi(spi_sdi));
    ccrs_top uut (.core_clk(core_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .sync_edge_position(sync_edge_position), .synth_enable(synth_enable),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ctrl(ctrl));
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rdat);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, rdat);
        chk($sformatf("reg %h", a), 24'(exp), 24'(rdat));
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        errors++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("ref drive", 24'h1, 24'(ctrl.synth_ref_output_drive));
        rd(15'h0030, 8'h00);
        rd(15'h0031, 8'hA0);
        rd(15'h0037, 8'h4B);
        rd(15'h003B, 8'h00);
        rd(15'h003C, 8'h01);
        rd(15'h003D, 8'h00);
        chk("sdo enable", 24'h0, 24'(spi_sdo_oe));
        rd(15'h002C, 8'h5A);
        rd(15'h002D, 8'hA5);
        rd(15'h002E, 8'hC3);
        wr(15'h002D, 8'h00);
        rd(15'h002D, 8'hA5);
        rd(15'h0040, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(15'h0030, 8'(i * 255));
            wr(15'h0031, i ? 8'hFF : 8'h20);
            chk("full scale", i ? 24'hFFFF : 24'h2000, 24'(ctrl.full_scale_adjust));
            rd(15'h0031, i ? 8'hFF : 8'h20);
        end
        wr(15'h0037, 8'h46);
        chk("low power", 24'h1, 24'(ctrl.low_power_sel));
        chk("profile code", 24'h46, 24'(ctrl.power_profile_code));
        wr(15'h0037, 8'h4B);
        chk("low power", 24'h0, 24'(ctrl.low_power_sel));
        chk("profile code", 24'h4B, 24'(ctrl.power_profile_code));
        for (int i = 0; i < 4; i++) begin
            wr(15'h003B, 8'(i));
            chk("ts enable", 24'(i[0]), 24'(ctrl.timestamp_input_enable));
            chk("ts pecl", 24'(i[1]), 24'(ctrl.timestamp_pecl_mode));
        end
        synth_enable <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("ref drive", 24'h0, 24'(ctrl.synth_ref_output_drive));
        synth_enable <= 1'b1;
        wr(15'h003C, 8'h00);
        chk("ref drive", 24'h0, 24'(ctrl.synth_ref_output_drive));
        for (int i = 0; i < 4; i++) begin
            wr(15'h003D, 8'(i * 5));
            chk("post", 24'(post_exp[i]), 24'(ctrl.post_div_ratio));
            chk("first", 24'(first_exp[i]), 24'(ctrl.first_div_ratio));
        end
        rd(15'h003D, 8'h0F);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("full scale", 24'hA000, 24'(ctrl.full_scale_adjust));
        chk("ref drive", 24'h1, 24'(ctrl.synth_ref_output_drive));
        rd(15'h003C, 8'h01);
        rd(15'h003D, 8'h00);
        stop_test;
    end
endmodule
